// ---- include/fsp_pkg.sv ----
// Package with constants and types for the full-scan and TAP test port
package fsp_pkg;
    localparam int FSP_CHAINS = 10;
    localparam int FSP_CHAIN_LEN = 16;
    localparam int FSP_REQ_LO = 2;
    localparam int FSP_REQ_HI = 6;
    localparam int FSP_IR_LEN = 4;
    localparam int FSP_DR_LEN = 32;
    localparam int FSP_BUF_DEPTH = 2;
    localparam logic [3:0] FSP_IR_RESET = 4'h1;
    localparam logic [3:0] FSP_IR_BYPASS = 4'hf;
    localparam logic [3:0] FSP_IR_STATUS = 4'h2;
    localparam logic [3:0] FSP_IR_CHAIN = 4'h3;
    localparam logic [31:0] FSP_ID_CODE = 32'h0000_0001; // Arbitrary value

    typedef enum logic [3:0] {
        FSP_TLR = 4'h0, FSP_RTI = 4'h1, FSP_SDR = 4'h2, FSP_CDR = 4'h3,
        FSP_SHDR = 4'h4, FSP_E1DR = 4'h5, FSP_PDR = 4'h6, FSP_E2DR = 4'h7,
        FSP_UDR = 4'h8, FSP_SIR = 4'h9, FSP_CIR = 4'ha, FSP_SHIR = 4'hb,
        FSP_E1IR = 4'hc, FSP_PIR = 4'hd, FSP_E2IR = 4'he, FSP_UIR = 4'hf
    } fsp_tap_e;

    function automatic fsp_tap_e fsp_tap_next(input fsp_tap_e s, input logic tms);
        case (s)
            FSP_TLR: fsp_tap_next = tms ? FSP_TLR : FSP_RTI;
            FSP_RTI: fsp_tap_next = tms ? FSP_SDR : FSP_RTI;
            FSP_SDR: fsp_tap_next = tms ? FSP_SIR : FSP_CDR;
            FSP_CDR: fsp_tap_next = tms ? FSP_E1DR : FSP_SHDR;
            FSP_SHDR: fsp_tap_next = tms ? FSP_E1DR : FSP_SHDR;
            FSP_E1DR: fsp_tap_next = tms ? FSP_UDR : FSP_PDR;
            FSP_PDR: fsp_tap_next = tms ? FSP_E2DR : FSP_PDR;
            FSP_E2DR: fsp_tap_next = tms ? FSP_UDR : FSP_SHDR;
            FSP_UDR: fsp_tap_next = tms ? FSP_SDR : FSP_RTI;
            FSP_SIR: fsp_tap_next = tms ? FSP_TLR : FSP_CIR;
            FSP_CIR: fsp_tap_next = tms ? FSP_E1IR : FSP_SHIR;
            FSP_SHIR: fsp_tap_next = tms ? FSP_E1IR : FSP_SHIR;
            FSP_E1IR: fsp_tap_next = tms ? FSP_UIR : FSP_PIR;
            FSP_PIR: fsp_tap_next = tms ? FSP_E2IR : FSP_PIR;
            FSP_E2IR: fsp_tap_next = tms ? FSP_UIR : FSP_SHIR;
            FSP_UIR: fsp_tap_next = tms ? FSP_SDR : FSP_RTI;
            default: fsp_tap_next = FSP_TLR;
        endcase
    endfunction
endpackage

// ---- include/fsp_word_if.sv ----
// Interface carrying words from the test clock domain to the system domain
`timescale 1ns/1ps
interface fsp_word_if;
    logic valid;
    logic ready;
    logic [31:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- logic/fsp_buf2.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module fsp_buf2
    import fsp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Streams
    fsp_word_if.snk in_if,
    fsp_word_if.src out_if
);
    typedef struct packed {
        logic [1:0][31:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } fsp_buf_s;
    fsp_buf_s st_r;
    fsp_buf_s st_nxt;

    assign in_if.ready = (st_r.cnt != 2'(FSP_BUF_DEPTH));
    assign out_if.valid = (st_r.cnt != 2'h0);
    assign out_if.data = st_r.mem[st_r.rp];

    always_comb begin
        st_nxt = st_r;
        if (in_if.valid && in_if.ready) begin
            st_nxt.mem[st_r.wp] = in_if.data;
            st_nxt.wp = ~st_r.wp;
        end
        if (out_if.valid && out_if.ready) begin
            st_nxt.rp = ~st_r.rp;
        end
        st_nxt.cnt = st_r.cnt + 2'(in_if.valid && in_if.ready)
                     - 2'(out_if.valid && out_if.ready);
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    a_buf_no_over: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        st_r.cnt <= 2'(FSP_BUF_DEPTH)) else $error("Buffer count above depth");
endmodule

// ---- logic/fsp_tap.sv ----
// TAP controller on the test clock with a status capture register
`timescale 1ns/1ps
module fsp_tap
    import fsp_pkg::*;
(
    // Test pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    input wire logic tap_shift_sel_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // Captured status word
    input wire logic [31:0] status_i,
    // Words sent to the system domain
    fsp_word_if.src word_if
);
    typedef struct packed {
        fsp_tap_e st;
        logic [FSP_IR_LEN-1:0] ir;
        logic [FSP_IR_LEN-1:0] irsh;
        logic [FSP_DR_LEN-1:0] drsh;
        logic [FSP_DR_LEN-1:0] upd;
        logic tgl;
    } fsp_tap_s;
    fsp_tap_s st_r;
    fsp_tap_s st_nxt;
    logic tdo_r;
    logic oe_r;
    logic [2:0] ack_q;

    always_comb begin
        st_nxt = st_r;
        st_nxt.st = fsp_tap_next(st_r.st, tms_i);
        case (st_r.st)
            FSP_TLR: st_nxt.ir = FSP_IR_RESET;
            FSP_CIR: st_nxt.irsh = FSP_IR_RESET;
            FSP_SHIR: begin
                if (tap_shift_sel_i) begin
                    st_nxt.irsh = {tdi_i, st_r.irsh[FSP_IR_LEN-1:1]};
                end
            end
            FSP_UIR: st_nxt.ir = st_r.irsh;
            FSP_CDR: begin
                if (st_r.ir == FSP_IR_STATUS) begin
                    st_nxt.drsh = status_i;
                end else if (st_r.ir == FSP_IR_BYPASS) begin
                    st_nxt.drsh = '0;
                end else begin
                    st_nxt.drsh = FSP_ID_CODE;
                end
            end
            FSP_SHDR: begin
                if (tap_shift_sel_i) begin
                    if (st_r.ir == FSP_IR_BYPASS) begin
                        st_nxt.drsh[0] = tdi_i;
                    end else begin
                        st_nxt.drsh = {tdi_i, st_r.drsh[FSP_DR_LEN-1:1]};
                    end
                end
            end
            FSP_UDR: begin
                if (st_r.ir == FSP_IR_CHAIN) begin
                    st_nxt.upd = st_r.drsh;
                    st_nxt.tgl = ~st_r.tgl;
                end
            end
            default: st_nxt.ir = st_r.ir;
        endcase
    end

    // Asynchronous test reset forces the initialized state
    always_ff @(posedge tck_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            st_r <= '{st: FSP_TLR, ir: FSP_IR_RESET, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Output changes on the falling test clock edge
    always_ff @(negedge tck_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            tdo_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            oe_r <= tap_shift_sel_i && (st_r.st == FSP_SHDR || st_r.st == FSP_SHIR);
            tdo_r <= (st_r.st == FSP_SHIR) ? st_r.irsh[0] : st_r.drsh[0];
        end
    end

    assign tdo_o = tdo_r;
    assign tdo_oe_o = oe_r;
    assign word_if.valid = st_r.tgl;
    assign word_if.data = st_r.upd;
    // Ready used only as a handshake level back from the system domain
    always_ff @(posedge tck_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            ack_q <= 3'h0;
        end else begin
            ack_q <= {ack_q[1:0], word_if.ready};
        end
    end

    a_tap_trst_init: assert property (@(posedge tck_i)
        !trst_n_i |-> st_r.st == FSP_TLR) else $error("TAP not reset");
    a_tap_tms_reset: assert property (@(posedge tck_i) disable iff (!trst_n_i)
        tms_i [*5] |=> st_r.st == FSP_TLR) else $error("Five TMS high missed reset");
    a_tap_ir_shift: assert property (@(posedge tck_i) disable iff (!trst_n_i)
        st_r.st == FSP_SHIR && tap_shift_sel_i |=> st_r.irsh[FSP_IR_LEN-1] == $past(tdi_i))
        else $error("IR shift lost TDI");
    c_tap_update: cover property (@(posedge tck_i) disable iff (!trst_n_i)
        st_r.st == FSP_UIR);
endmodule

// ---- logic/fsp_test_port.sv ----
// Full-scan test mode and boundary-scan TAP of the bridge test port
`timescale 1ns/1ps
// Notes on behaviour
// - Low full-scan mode pin enables ten internal scan chains; high is normal.
// - In full-scan mode all chains clock from the primary bus clock only.
// - Request inputs 6..2 of both buses are scan inputs; grants 6..2 scan outputs.
// - Full-scan active and select low: chains shift on each scan clock.
// - Full-scan active and select high: chains perform parallel capture; the code shifts capture_data_i into bit 0 of each chain instead.
// - Select high: TAP shifts data out serially on TDO, timed by TCK.
// - Select high: TDI bits shift into the TAP, timed by TCK.
// - TAP state advances by TMS sampled on TCK.
// - Low test reset forces the TAP to its initialized state, regardless of TMS/TCK.
// - TCK clocks all state and data moves during boundary scan.
module fsp_test_port
    import fsp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Full-scan control pins
    input wire logic full_scan_mode_n_i,
    input wire logic scan_capture_sel_i,
    // Secondary bus request pins
    input wire logic [7:0] sec1_bus_request_n_i,
    input wire logic [6:0] sec2_bus_request_n_i,
    // Secondary bus grant pins
    output logic [7:0] sec1_bus_grant_n_o,
    output logic [6:0] sec2_bus_grant_n_o,
    // Grants from the functional arbiter
    input wire logic [7:0] arb1_grant_n_i,
    input wire logic [6:0] arb2_grant_n_i,
    // Requests to the functional arbiter
    output logic [7:0] arb1_request_n_o,
    output logic [6:0] arb2_request_n_o,
    // Functional state captured in parallel mode
    input wire logic [FSP_CHAINS-1:0] capture_data_i,
    // Scan mode status
    output logic scan_active_o,
    // Boundary-scan pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // Words loaded through the TAP
    output logic tap_word_valid_o,
    output logic [31:0] tap_word_o,
    input wire logic tap_word_ready_i
);
    typedef logic [FSP_CHAIN_LEN-1:0] fsp_chain_t;

    typedef struct packed {
        logic [2:0] mode_q;
        logic [2:0] sel_q;
        logic scan_on;
        logic cap_on;
        logic [FSP_CHAINS-1:0][FSP_CHAIN_LEN-1:0] chain;
        logic [FSP_CHAINS-1:0] sout;
        logic [2:0] tgl_q;
        logic tgl_seen;
    } fsp_top_s;
    fsp_top_s st_r;
    fsp_top_s st_nxt;

    logic [FSP_CHAINS-1:0] scan_in;
    logic [31:0] status_word;
    logic tgl_edge;

    fsp_word_if tap_if ();
    fsp_word_if out_if ();
    fsp_word_if sync_if ();

    // Scan inputs: sec1 requests 6..2 then sec2 requests 6..2
    assign scan_in = {sec1_bus_request_n_i[FSP_REQ_HI:FSP_REQ_LO],
                      sec2_bus_request_n_i[FSP_REQ_HI:FSP_REQ_LO]};

    always_comb begin
        st_nxt = st_r;
        st_nxt.mode_q = {st_r.mode_q[1:0], ~full_scan_mode_n_i};
        st_nxt.sel_q = {st_r.sel_q[1:0], scan_capture_sel_i};
        if (st_r.mode_q[2] == st_r.mode_q[1]) begin
            st_nxt.scan_on = st_r.mode_q[1];
        end
        if (st_r.sel_q[2] == st_r.sel_q[1]) begin
            st_nxt.cap_on = st_r.sel_q[1];
        end
        for (int i = 0; i < FSP_CHAINS; i++) begin
            if (st_r.scan_on && !st_r.cap_on) begin
                st_nxt.chain[i] = {st_r.chain[i][FSP_CHAIN_LEN-2:0], scan_in[i]};
            end else if (st_r.scan_on) begin
                st_nxt.chain[i] = {st_r.chain[i][FSP_CHAIN_LEN-2:0], capture_data_i[i]};
            end
            st_nxt.sout[i] = st_nxt.chain[i][FSP_CHAIN_LEN-1];
        end
        st_nxt.tgl_q = {st_r.tgl_q[1:0], tap_if.valid};
        // Buffer acceptance clears the flag; a new toggle in the same cycle wins
        if (st_r.tgl_seen && sync_if.ready) begin
            st_nxt.tgl_seen = 1'b0;
        end
        if (st_r.tgl_q[2] != st_r.tgl_q[1]) begin
            st_nxt.tgl_seen = 1'b1;
        end
    end

    // Scan chains run on the primary clock only
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tgl_edge = st_r.tgl_seen;

    // Pin muxing between functional arbiter and scan outputs
    generate
        for (genvar g = 0; g < 8; g++) begin : g_s1
            if (g >= FSP_REQ_LO && g <= FSP_REQ_HI) begin : g_scan
                assign sec1_bus_grant_n_o[g] = st_r.scan_on ?
                    st_r.sout[FSP_CHAINS/2 + g - FSP_REQ_LO] : arb1_grant_n_i[g];
                assign arb1_request_n_o[g] = st_r.scan_on ? 1'b1 :
                    sec1_bus_request_n_i[g];
            end else begin : g_pass
                assign sec1_bus_grant_n_o[g] = arb1_grant_n_i[g];
                assign arb1_request_n_o[g] = sec1_bus_request_n_i[g];
            end
        end
        for (genvar g = 0; g < 7; g++) begin : g_s2
            if (g >= FSP_REQ_LO && g <= FSP_REQ_HI) begin : g_scan
                assign sec2_bus_grant_n_o[g] = st_r.scan_on ?
                    st_r.sout[g - FSP_REQ_LO] : arb2_grant_n_i[g];
                assign arb2_request_n_o[g] = st_r.scan_on ? 1'b1 :
                    sec2_bus_request_n_i[g];
            end else begin : g_pass
                assign sec2_bus_grant_n_o[g] = arb2_grant_n_i[g];
                assign arb2_request_n_o[g] = sec2_bus_request_n_i[g];
            end
        end
    endgenerate

    assign scan_active_o = st_r.scan_on;
    assign status_word = {20'h0, st_r.sout, st_r.cap_on, st_r.scan_on};

    fsp_tap u_tap (
        .tck_i(tck_i),
        .tms_i(tms_i),
        .tdi_i(tdi_i),
        .trst_n_i(trst_n_i),
        .tap_shift_sel_i(scan_capture_sel_i),
        .tdo_o(tdo_o),
        .tdo_oe_o(tdo_oe_o),
        .status_i(status_word),
        .word_if(tap_if)
    );

    // Toggle event crosses to the system domain; data stable once toggled
    assign sync_if.valid = tgl_edge;
    assign sync_if.data = tap_if.data;
    assign tap_if.ready = 1'b1;

    fsp_buf2 u_buf (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_if(sync_if),
        .out_if(out_if)
    );
    assign tap_word_valid_o = out_if.valid;
    assign tap_word_o = out_if.data;
    assign out_if.ready = tap_word_ready_i;

    a_scan_mode_on: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        full_scan_mode_n_i [*5] |-> !st_r.scan_on) else $error("Scan stayed on");
    a_scan_shift_op: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        st_r.scan_on && !st_r.cap_on |=> st_r.chain[0][0] == $past(scan_in[0]))
        else $error("Shift did not load scan input");
    a_scan_capture_op: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        st_r.scan_on && st_r.cap_on |=> st_r.chain[0][0] == $past(capture_data_i[0]))
        else $error("Capture missed data");
    a_scan_grant_out: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        st_r.scan_on |-> sec2_bus_grant_n_o[FSP_REQ_LO] == st_r.sout[0])
        else $error("Grant pin not scan output");
    a_func_grant_pass: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !st_r.scan_on |-> sec1_bus_grant_n_o == arb1_grant_n_i)
        else $error("Grant pins disturbed");
    a_func_req_pass: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !st_r.scan_on |-> arb2_request_n_o == sec2_bus_request_n_i)
        else $error("Request pins disturbed");
    a_scan_clk_only: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !st_r.scan_on |=> $stable(st_r.chain)) else $error("Chains moved outside scan");
    a_word_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        tap_word_valid_o && !tap_word_ready_i |=> tap_word_valid_o)
        else $error("Word dropped under stall");
    c_scan_shift: cover property (@(posedge ref_clk_i) st_r.scan_on && !st_r.cap_on);
    c_scan_cap: cover property (@(posedge ref_clk_i) st_r.scan_on && st_r.cap_on);
    c_word_out: cover property (@(posedge ref_clk_i) tap_word_valid_o && tap_word_ready_i);
endmodule

// ---- sim/fsp_tester.sv ----
// Tester model driving the boundary-scan pins of the test port
`timescale 1ns/1ps
module fsp_tester (
    // Test pins towards the device
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o,
    // Test data from the device
    input wire logic tdo_i
);
    localparam realtime HALF = 62.5;

    // Test clock stands still low between frames; pulled-up lines idle high
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        trst_n_o = 1'b0;
    end

    // One test clock: pins change while low, data sampled on the rise
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #(HALF);
        tck_o = 1'b1;
        tdo = tdo_i;
        #(HALF);
        tck_o = 1'b0;
    endtask

    // Hold test reset across one clock with TMS low, then step to idle
    task automatic reset_tap();
        logic d;
        trst_n_o = 1'b0;
        tick(1'b0, 1'b1, d);
        trst_n_o = 1'b1;
        #(HALF);
        tick(1'b0, 1'b1, d);
    endtask

    // Walk from idle, shift n bits LSB first, update and return to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic d;
        dout = '0;
        #1.7;
        tick(1'b1, 1'b1, d);
        if (ir) begin
            tick(1'b1, 1'b1, d);
        end
        tick(1'b0, 1'b1, d);
        tick(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], d);
            dout[i] = d;
        end
        tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
        tdi_o = 1'b1;
    endtask
endmodule

// ---- sim/testbench.sv ----
// Self-checking testbench for the full-scan and TAP test port
`timescale 1ns/1ps
module testbench;
    import fsp_pkg::*;

    typedef struct packed {
        logic mode_n;
        logic [7:0] req1;
        logic [6:0] req2;
        logic [7:0] arb1;
        logic [6:0] arb2;
        logic [7:0] m1;
        logic [6:0] m2;
        logic [7:0] g1;
        logic [6:0] g2;
        logic [7:0] ar1;
        logic [6:0] ar2;
    } fsp_row_s;

    // Mode, pins, arbiter, compare mask, then expected grants and requests
    localparam fsp_row_s ROWS [0:3] = '{
        '{1'b1, 8'ha5, 7'h5a, 8'h3c, 7'h21, 8'hff, 7'h7f, 8'h3c, 7'h21, 8'ha5, 7'h5a},
        '{1'b1, 8'hff, 7'h7f, 8'h00, 7'h00, 8'hff, 7'h7f, 8'h00, 7'h00, 8'hff, 7'h7f},
        '{1'b0, 8'h54, 7'h28, 8'hff, 7'h7f, 8'h7c, 7'h7c, 8'h54, 7'h28, 8'h7c, 7'h7c},
        '{1'b0, 8'h28, 7'h54, 8'h00, 7'h00, 8'h7c, 7'h7c, 8'h28, 7'h54, 8'h7c, 7'h7c}
    };

    logic ref_clk_i;
    logic sys_rst_i;
    logic mode_n;
    logic sel;
    logic [7:0] req1;
    logic [6:0] req2;
    logic [7:0] arb1;
    logic [6:0] arb2;
    logic [9:0] cap;
    logic rdy;
    logic [7:0] g1;
    logic [6:0] g2;
    logic [7:0] ar1;
    logic [6:0] ar2;
    logic act;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tdo;
    logic tdo_oe;
    logic wv;
    logic [31:0] wd;
    int err_total = 0;
    int checks_done = 0;
    int oe_lo = 0;
    int oe_hi = 0;

    // Count test clocks with the data output enabled, split by select level
    always @(posedge tck) begin
        if (tdo_oe === 1'b1 && sel === 1'b0) begin
            oe_lo++;
        end
        if (tdo_oe === 1'b1 && sel === 1'b1) begin
            oe_hi++;
        end
    end

    always #2.5 ref_clk_i = ~ref_clk_i;

    fsp_test_port u_fsp_test_port (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .full_scan_mode_n_i(mode_n), .scan_capture_sel_i(sel),
        .sec1_bus_request_n_i(req1), .sec2_bus_request_n_i(req2),
        .sec1_bus_grant_n_o(g1), .sec2_bus_grant_n_o(g2),
        .arb1_grant_n_i(arb1), .arb2_grant_n_i(arb2),
        .arb1_request_n_o(ar1), .arb2_request_n_o(ar2),
        .capture_data_i(cap), .scan_active_o(act),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .tap_word_valid_o(wv), .tap_word_o(wd), .tap_word_ready_i(rdy)
    );

    fsp_tester u_fsp_tester (
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Accept one word: wait for valid, compare, then hold ready for one rising edge
    task automatic pop(input logic [31:0] exp);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (wv !== 1'b1 && n < 50) begin
            @(negedge ref_clk_i);
            n++;
        end
        check(wv, 1'b1, "word valid");
        check(wd, exp, "word data");
        rdy = 1'b1;
        @(negedge ref_clk_i);
        rdy = 1'b0;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #300us;
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        conclude();
    end

    initial begin
        logic [31:0] dout;
        logic d;
        ref_clk_i = 1'b0;
        sys_rst_i = 1'b1;
        mode_n = 1'b1;
        sel = 1'b0;
        req1 = 8'hff;
        req2 = 7'h7f;
        arb1 = 8'hff;
        arb2 = 7'h7f;
        cap = 10'h000;
        rdy = 1'b0;
        repeat (12) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        foreach (ROWS[k]) begin
            mode_n = ROWS[k].mode_n;
            req1 = ROWS[k].req1;
            req2 = ROWS[k].req2;
            arb1 = ROWS[k].arb1;
            arb2 = ROWS[k].arb2;
            repeat (30) @(negedge ref_clk_i);
            check(act, !ROWS[k].mode_n, "scan active");
            check(g1 & ROWS[k].m1, ROWS[k].g1, "grant 1");
            check(g2 & ROWS[k].m2, ROWS[k].g2, "grant 2");
            check(ar1 & ROWS[k].m1, ROWS[k].ar1, "request 1");
            check(ar2 & ROWS[k].m2, ROWS[k].ar2, "request 2");
        end
        $display("test pin rows done");
        cap = {req1[6:2], req2[6:2]};
        sel = 1'b1;
        req1 = ~req1;
        req2 = ~req2;
        repeat (25) @(negedge ref_clk_i);
        check(g1 & 8'h7c, 8'h28, "capture grant 1");
        check(g2 & 7'h7c, 7'h54, "capture grant 2");
        sel = 1'b0;
        repeat (25) @(negedge ref_clk_i);
        check(g1 & 8'h7c, 8'h54, "shift grant 1");
        check(g2 & 7'h7c, 7'h28, "shift grant 2");
        mode_n = 1'b1;
        sel = 1'b1;
        arb1 = 8'h96;
        arb2 = 7'h69;
        repeat (10) @(negedge ref_clk_i);
        check(g1, 8'h96, "normal grant 1");
        check(g2, 7'h69, "normal grant 2");
        check(ar1, 8'hd7, "normal request 1");
        check(ar2, 7'h2b, "normal request 2");
        $display("test capture and exit done");
        u_fsp_tester.reset_tap();
        u_fsp_tester.scan(1'b0, 32, 32'h0, dout);
        check(dout, FSP_ID_CODE, "id after reset");
        u_fsp_tester.scan(1'b1, 4, {28'h0, FSP_IR_BYPASS}, dout);
        u_fsp_tester.scan(1'b0, 8, 32'hb6, dout);
        check(dout, 32'h6c, "bypass path");
        repeat (5) u_fsp_tester.tick(1'b1, 1'b1, d);
        u_fsp_tester.tick(1'b0, 1'b1, d);
        u_fsp_tester.scan(1'b0, 32, 32'h0, dout);
        check(dout, FSP_ID_CODE, "id after mode select reset");
        u_fsp_tester.reset_tap();
        u_fsp_tester.scan(1'b0, 32, 32'h0, dout);
        check(dout, FSP_ID_CODE, "id after second reset");
        $display("test tap done");
        u_fsp_tester.scan(1'b1, 4, {28'h0, FSP_IR_CHAIN}, dout);
        u_fsp_tester.scan(1'b0, 32, 32'h1234_5678, dout);
        u_fsp_tester.scan(1'b0, 32, 32'h9abc_def0, dout);
        repeat (40) @(negedge ref_clk_i);
        check(wv, 1'b1, "word held");
        check(wd, 32'h1234_5678, "held word");
        pop(32'h1234_5678);
        pop(32'h9abc_def0);
        repeat (10) @(negedge ref_clk_i);
        check(wv, 1'b0, "buffer drained");
        $display("test word stream done");
        sel = 1'b0;
        u_fsp_tester.scan(1'b0, 32, 32'hffff_0000, dout);
        check(tdo_oe, 1'b0, "output off when select low");
        check(oe_lo, 0, "output enabled with select low");
        check(oe_hi > 0, 1'b1, "output never enabled with select high");
        pop(FSP_ID_CODE);
        $display("test select low done");
        mode_n = 1'b0;
        repeat (10) @(negedge ref_clk_i);
        check(act, 1'b1, "scan on before reset");
        sys_rst_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check(act, 1'b0, "scan off in reset");
        check(g1, arb1, "grant pass in reset");
        sys_rst_i = 1'b0;
        repeat (10) @(negedge ref_clk_i);
        check(act, 1'b1, "scan on after reset");
        $display("test mid-run reset done");
        conclude();
    end
endmodule
